// ===== rdtl_pkg.sv
// Package for the run direction terminal logic: register map, codes and types
package rdtl_pkg;

    // ==========================================
    // Register map (byte addresses)
    localparam logic [7:0] ADDR_CTRL   = 8'h00;
    localparam logic [7:0] ADDR_ASSIGN = 8'h04;
    localparam logic [7:0] ADDR_POLAR  = 8'h08;
    localparam logic [7:0] ADDR_STATUS = 8'h0C;

    // ==========================================
    // Field layout and values
    localparam int          NUM_TERMS      = 8;
    localparam int          CODE_W         = 8;
    localparam logic [7:0]  FUNC_REVERSE   = 8'h01;
    localparam logic [7:0]  FUNC_NONE      = 8'hFF;
    localparam logic [1:0]  SRC_TERMINALS  = 2'h1;
    localparam int          CTRL_SRC_LSB   = 0;
    localparam int          CTRL_KEYREV    = 2;
    localparam int          POL_FWD_BIT    = 8;
    localparam logic [31:0] ASSIGN_RESET   = 32'h0000_0000;
    localparam logic [1:0]  AXI_OKAY       = 2'b00;
    localparam logic [1:0]  AXI_DECERR     = 2'b11;
    localparam int          ADDR_W         = 8;

    typedef enum logic [1:0] {
        RDTL_STOP,
        RDTL_FWD,
        RDTL_REV
    } rdtl_dir_t;

    typedef struct packed {
        logic [1:0] run_source_setting;
        logic       keypad_direction_setting;
        logic [8:0] polarity_nc;
    } rdtl_cfg_t;

    typedef struct packed {
        logic      fwd;
        logic      rev;
        rdtl_dir_t dir;
    } rdtl_req_t;

endpackage

// ===== rdtl_code_mem.sv
// Function code table: one code per programmable input terminal
`timescale 1ns/1ns
module rdtl_code_mem (
    input  wire logic                                aclk,      // Clock
    input  wire logic                                aresetn,   // Sync reset, active low
    input  wire logic                                wr_en,     // Write strobe
    input  wire logic [2:0]                          wr_idx,    // Terminal to write
    input  wire logic [rdtl_pkg::CODE_W-1:0]         wr_code,   // Code to store
    output logic [rdtl_pkg::NUM_TERMS-1:0]           rev_sel_q  // Terminal holds reverse code
);

    logic [rdtl_pkg::CODE_W-1:0] code_q [rdtl_pkg::NUM_TERMS];

    // ==========================================
    // Per terminal storage, all terminals alike
    genvar g;
    generate
        for (g = 0; g < rdtl_pkg::NUM_TERMS; g++) begin : g_term
            always_ff @(posedge aclk) begin
                if (!aresetn) begin
                    code_q[g]    <= rdtl_pkg::FUNC_NONE;
                    rev_sel_q[g] <= 1'b0;
                end else begin
                    if (wr_en && (wr_idx == 3'(g))) begin
                        code_q[g] <= wr_code;
                    end
                    rev_sel_q[g] <= (code_q[g] == rdtl_pkg::FUNC_REVERSE);
                end
            end
        end
    endgenerate

endmodule

// ===== rdtl_top.sv
// Run direction terminal decoder with AXI4-Lite registers
// Functional notes
// - Forward input high requests forward run; low requests stop.
// - Terminal assigned reverse function high requests reverse; low requests stop.
// - Forward and reverse both active gives stop, no direction chosen.
// - Normally-closed terminal reads open as active, starting rotation.
// - Keypad direction setting affects only keypad run key, not terminals.
// - Eight programmable terminals identical; reverse code 01 fits any one.
// - Forward function sits on a fixed dedicated terminal.
// - Run request present at power-up starts rotation immediately; here source resets to keypad, so held terminals wait for source set.
//
// Register access over AXI4-Lite and the register offsets were chosen for this implementation.
`timescale 1ns/1ns
module rdtl_top (
    input  wire logic        aclk,          // Clock, 25 MHz
    input  wire logic        aresetn,       // Sync reset, active low
    input  wire logic        forward_run_input, // Dedicated forward terminal
    input  wire logic [7:0]  prog_in,       // Programmable input terminals
    input  wire logic        keypad_run,    // Keypad run key
    output logic             run_fwd_q,     // Forward rotation request
    output logic             run_rev_q,     // Reverse rotation request
    output logic             stop_q,        // Stop request
    input  wire logic [7:0]  s_axi_awaddr,  // Write address
    input  wire logic        s_axi_awvalid, // Write address valid
    output logic             s_axi_awready, // Write address ready
    input  wire logic [31:0] s_axi_wdata,   // Write data
    input  wire logic [3:0]  s_axi_wstrb,   // Write strobes
    input  wire logic        s_axi_wvalid,  // Write data valid
    output logic             s_axi_wready,  // Write data ready
    output logic [1:0]       s_axi_bresp,   // Write response
    output logic             s_axi_bvalid,  // Write response valid
    input  wire logic        s_axi_bready,  // Write response ready
    input  wire logic [7:0]  s_axi_araddr,  // Read address
    input  wire logic        s_axi_arvalid, // Read address valid
    output logic             s_axi_arready, // Read address ready
    output logic [31:0]      s_axi_rdata,   // Read data
    output logic [1:0]       s_axi_rresp,   // Read response
    output logic             s_axi_rvalid,  // Read data valid
    input  wire logic        s_axi_rready   // Read data ready
);

    typedef struct packed {
        logic                aw_got;
        logic [7:0]          aw_addr;
        logic                w_got;
        logic [31:0]         w_data;
        logic [3:0]          w_strb;
        logic                bvalid;
        logic [1:0]          bresp;
        logic                rvalid;
        logic [1:0]          rresp;
        logic [31:0]         rdata;
        rdtl_pkg::rdtl_cfg_t cfg;
        rdtl_pkg::rdtl_req_t req;
    } rdtl_state_t;

    rdtl_state_t s_q;
    rdtl_state_t s_d;

    logic [7:0] rev_sel;
    logic       mem_wr;
    logic [7:0] term_act;
    logic       fwd_act;
    logic       rev_act;
    logic       term_mode;

    // ==========================================
    // Function code storage
    rdtl_code_mem u_mem (
        .aclk      (aclk),
        .aresetn   (aresetn),
        .wr_en     (mem_wr),
        .wr_idx    (s_q.w_data[10:8]),
        .wr_code   (s_q.w_data[7:0]),
        .rev_sel_q (rev_sel)
    );

    // ==========================================
    // Terminal decode
    always_comb begin
        term_act = prog_in ^ s_q.cfg.polarity_nc[7:0];
        fwd_act  = forward_run_input ^ s_q.cfg.polarity_nc[rdtl_pkg::POL_FWD_BIT];
        rev_act  = |(term_act & rev_sel);
        term_mode = (s_q.cfg.run_source_setting == rdtl_pkg::SRC_TERMINALS);
    end

    assign mem_wr = s_q.aw_got && s_q.w_got && !s_q.bvalid
                    && (s_q.aw_addr == rdtl_pkg::ADDR_ASSIGN) && s_q.w_strb[0];

    // ==========================================
    // Next state
    always_comb begin
        s_d = s_q;
        // Write channels taken in either order
        if (s_axi_awvalid && !s_q.aw_got) begin
            s_d.aw_got  = 1'b1;
            s_d.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && !s_q.w_got) begin
            s_d.w_got  = 1'b1;
            s_d.w_data = s_axi_wdata;
            s_d.w_strb = s_axi_wstrb;
        end
        if (s_q.aw_got && s_q.w_got && !s_q.bvalid) begin
            s_d.bvalid = 1'b1;
            s_d.bresp  = rdtl_pkg::AXI_OKAY;
            if (s_q.aw_addr == rdtl_pkg::ADDR_CTRL) begin
                if (s_q.w_strb[0]) begin
                    s_d.cfg.run_source_setting = s_q.w_data[rdtl_pkg::CTRL_SRC_LSB +: 2];
                    s_d.cfg.keypad_direction_setting = s_q.w_data[rdtl_pkg::CTRL_KEYREV];
                end
            end else if (s_q.aw_addr == rdtl_pkg::ADDR_POLAR) begin
                if (s_q.w_strb[0]) begin
                    s_d.cfg.polarity_nc[7:0] = s_q.w_data[7:0];
                end
                if (s_q.w_strb[1]) begin
                    s_d.cfg.polarity_nc[8] = s_q.w_data[8];
                end
            end else if (s_q.aw_addr != rdtl_pkg::ADDR_ASSIGN) begin
                s_d.bresp = rdtl_pkg::AXI_DECERR;
            end
        end
        if (s_q.bvalid && s_axi_bready) begin
            s_d.bvalid = 1'b0;
            s_d.aw_got = 1'b0;
            s_d.w_got  = 1'b0;
        end
        // Read
        if (s_axi_arvalid && !s_q.rvalid) begin
            s_d.rvalid = 1'b1;
            s_d.rresp  = rdtl_pkg::AXI_OKAY;
            s_d.rdata  = 32'h0000_0000;
            if (s_axi_araddr == rdtl_pkg::ADDR_CTRL) begin
                s_d.rdata[2:0] = {s_q.cfg.keypad_direction_setting,
                                  s_q.cfg.run_source_setting};
            end else if (s_axi_araddr == rdtl_pkg::ADDR_ASSIGN) begin
                s_d.rdata[7:0] = rev_sel;
            end else if (s_axi_araddr == rdtl_pkg::ADDR_POLAR) begin
                s_d.rdata[8:0] = s_q.cfg.polarity_nc;
            end else if (s_axi_araddr == rdtl_pkg::ADDR_STATUS) begin
                s_d.rdata[3:0] = {s_q.req.fwd, s_q.req.rev, s_q.req.dir};
            end else begin
                s_d.rresp = rdtl_pkg::AXI_DECERR;
            end
        end else if (s_q.rvalid && s_axi_rready) begin
            s_d.rvalid = 1'b0;
        end
        // Direction request; no start latch, so an active input runs at once
        s_d.req.fwd = 1'b0;
        s_d.req.rev = 1'b0;
        s_d.req.dir = rdtl_pkg::RDTL_STOP;
        if (term_mode) begin
            s_d.req.fwd = fwd_act;
            s_d.req.rev = rev_act;
            if (fwd_act && !rev_act) begin
                s_d.req.dir = rdtl_pkg::RDTL_FWD;
            end else if (rev_act && !fwd_act) begin
                s_d.req.dir = rdtl_pkg::RDTL_REV;
            end else begin
                s_d.req.dir = rdtl_pkg::RDTL_STOP;
            end
        end else if (keypad_run) begin
            // Keypad key only, terminals untouched
            s_d.req.dir = s_q.cfg.keypad_direction_setting ? rdtl_pkg::RDTL_REV
                                                           : rdtl_pkg::RDTL_FWD;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    // ==========================================
    // Outputs
    assign run_fwd_q     = (s_q.req.dir == rdtl_pkg::RDTL_FWD);
    assign run_rev_q     = (s_q.req.dir == rdtl_pkg::RDTL_REV);
    assign stop_q        = (s_q.req.dir == rdtl_pkg::RDTL_STOP);
    assign s_axi_awready = !s_q.aw_got;
    assign s_axi_wready  = !s_q.w_got;
    assign s_axi_bvalid  = s_q.bvalid;
    assign s_axi_bresp   = s_q.bresp;
    assign s_axi_arready = !s_q.rvalid;
    assign s_axi_rvalid  = s_q.rvalid;
    assign s_axi_rresp   = s_q.rresp;
    assign s_axi_rdata   = s_q.rdata;

    // ==========================================
    // Checks
    sequence both_on;
        term_mode && fwd_act && rev_act;
    endsequence

    a_fwd_run_req: assert property (@(posedge aclk) disable iff (!aresetn)
        (term_mode && fwd_act && !rev_act) |=> run_fwd_q)
        else $error("forward request not raised");
    a_rev_run_req: assert property (@(posedge aclk) disable iff (!aresetn)
        (term_mode && rev_act && !fwd_act && !$past(mem_wr)) |=> run_rev_q)
        else $error("reverse request not raised");
    a_both_stop: assert property (@(posedge aclk) disable iff (!aresetn)
        both_on |=> stop_q && !run_fwd_q && !run_rev_q)
        else $error("both active did not stop");
    a_nc_polarity: assert property (@(posedge aclk) disable iff (!aresetn)
        (term_mode && s_q.cfg.polarity_nc[8] && !forward_run_input && !rev_act) |=> run_fwd_q)
        else $error("open nc terminal not active");
    a_keypad_isol: assert property (@(posedge aclk) disable iff (!aresetn)
        (term_mode && !fwd_act && !rev_act && keypad_run) |=> stop_q)
        else $error("keypad affected terminals");
    a_rev_any_term: assert property (@(posedge aclk) disable iff (!aresetn)
        (term_mode && |(term_act & rev_sel)) |=> s_q.req.rev)
        else $error("reverse terminal ignored");
    a_src_gate: assert property (@(posedge aclk) disable iff (!aresetn)
        !term_mode |=> !s_q.req.fwd && !s_q.req.rev)
        else $error("terminals acted outside terminal mode");
    a_one_dir: assert property (@(posedge aclk) disable iff (!aresetn)
        $onehot({run_fwd_q, run_rev_q, stop_q}))
        else $error("direction outputs not one hot");

endmodule

// ===== rdtl_switch_model.sv
// Partner model: external switches or solid-state outputs on the input terminals
`timescale 1ns/1ns
module rdtl_switch_model (
    input  wire logic       sw_fwd,            // Forward switch closed
    input  wire logic [7:0] sw_prog,           // Programmable switches closed
    output logic            forward_run_input, // Forward terminal level
    output logic [7:0]      prog_in            // Programmable terminal levels
);
    // Open contact carries no voltage, so the terminal reads low
    assign forward_run_input = sw_fwd;
    assign prog_in           = sw_prog;
endmodule

// ===== tb_top.sv
// Testbench: register and terminal scenarios for the run direction decoder
`timescale 1ns/1ns
module tb_top;
    logic aclk = 0, aresetn = 0, keypad_run = 0, sw_fwd = 0;
    logic [7:0] sw_prog = 0, awaddr = 0, araddr = 0;
    logic awvalid = 0, wvalid = 0, bready = 0, arvalid = 0, rready = 0;
    logic [31:0] wdata = 0, rdata;
    logic [3:0] wstrb = 0;
    logic fwd_in, run_fwd_q, run_rev_q, stop_q, awready, wready, bvalid, arready, rvalid;
    logic [7:0] prog_in;
    logic [1:0] bresp, rresp;
    logic [31:0] rd;
    logic [1:0] rsp;
    int mismatches = 0, checks = 0, i;
    always #20 aclk = ~aclk;
    rdtl_switch_model rdtl_switch_model_i (.sw_fwd(sw_fwd), .sw_prog(sw_prog),
        .forward_run_input(fwd_in), .prog_in(prog_in));
    rdtl_top rdtl_top_i (.aclk(aclk), .aresetn(aresetn), .forward_run_input(fwd_in),
        .prog_in(prog_in), .keypad_run(keypad_run), .run_fwd_q(run_fwd_q),
        .run_rev_q(run_rev_q), .stop_q(stop_q), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
        .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
        .s_axi_rready(rready));
    task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        checks++;
        if (got !== exp) begin
            mismatches++;
            $display("ERROR %s expected %h seen %h", nm, exp, got);
        end
    endtask
    // Entered just after a rising edge; readies are sampled mid-cycle, stable to the edge
    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
        logic aw, w;
        aw = 0;
        w = 0;
        awaddr <= a; wdata <= d; wstrb <= 4'hF; awvalid <= 1; wvalid <= 1;
        while (!(aw && w)) begin
            @(negedge aclk);
            if (awready && awvalid) aw = 1;
            if (wready && wvalid) w = 1;
            @(posedge aclk);
            if (aw) awvalid <= 0;
            if (w) wvalid <= 0;
        end
        bready <= 1;
        @(negedge aclk);
        while (!bvalid) begin
            @(negedge aclk);
        end
        rsp = bresp;
        @(posedge aclk);
        bready <= 0;
    endtask
    task automatic axi_rd(input logic [7:0] a);
        araddr <= a; arvalid <= 1;
        @(negedge aclk);
        while (!arready) begin
            @(negedge aclk);
        end
        @(posedge aclk);
        arvalid <= 0;
        rready <= 1;
        @(negedge aclk);
        while (!rvalid) begin
            @(negedge aclk);
        end
        rd = rdata;
        rsp = rresp;
        @(posedge aclk);
        rready <= 0;
    endtask
    task automatic chk_dir(input string nm, input logic [2:0] exp);
        repeat (2) @(posedge aclk);
        @(negedge aclk);
        chk(nm, {29'h0, exp}, {29'h0, run_fwd_q, run_rev_q, stop_q});
        @(posedge aclk);
    endtask
    task automatic test_done;
        $display("Counts: %0d checks, %0d mismatches", checks, mismatches);
        if (mismatches == 0 && checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    initial begin
        #(40 * 20000);
        mismatches++;
        test_done();
    end
    initial begin
        repeat (2) @(posedge aclk);
        aresetn <= 1;
        @(negedge aclk);
        chk("reset dir", 3'b001, {run_fwd_q, run_rev_q, stop_q});
        @(posedge aclk);
        // Source not terminals: terminals ignored, keypad follows its setting
        sw_fwd <= 1;
        chk_dir("src off fwd", 3'b001);
        sw_fwd <= 0; keypad_run <= 1;
        axi_wr(rdtl_pkg::ADDR_CTRL, 32'h0000_0004);
        chk_dir("keypad rev", 3'b010);
        axi_wr(rdtl_pkg::ADDR_CTRL, 32'h0000_0005);
        chk("ctrl wr resp", {30'h0, rdtl_pkg::AXI_OKAY}, {30'h0, rsp});
        chk_dir("keypad ignored", 3'b001);
        $display("Test source selection done");
        sw_fwd <= 1;
        chk_dir("fwd on", 3'b100);
        axi_rd(rdtl_pkg::ADDR_STATUS);
        chk("status fwd", 32'h0000_0009, rd);
        sw_fwd <= 0;
        chk_dir("fwd off", 3'b001);
        $display("Test forward done");
        for (i = 0; i < 8; i++) begin
            axi_wr(rdtl_pkg::ADDR_ASSIGN, {21'h0, i[2:0], rdtl_pkg::FUNC_REVERSE});
            axi_rd(rdtl_pkg::ADDR_ASSIGN);
            chk("assign map", 32'h1 << i, rd);
            sw_prog <= ~(8'h01 << i);
            chk_dir("other terms", 3'b001);
            sw_prog <= 8'h01 << i;
            chk_dir("rev on", 3'b010);
            sw_fwd <= 1;
            chk_dir("both", 3'b001);
            sw_fwd <= 0; sw_prog <= 0;
            chk_dir("rev off", 3'b001);
            axi_wr(rdtl_pkg::ADDR_ASSIGN, {21'h0, i[2:0], rdtl_pkg::FUNC_NONE});
        end
        $display("Test reverse terminals done");
        // Normally closed forward terminal left open runs at once
        axi_wr(rdtl_pkg::ADDR_POLAR, 32'h0000_0100);
        chk_dir("nc fwd open", 3'b100);
        sw_fwd <= 1;
        chk_dir("nc fwd closed", 3'b001);
        // Normally closed reverse terminal left open requests reverse
        sw_fwd <= 0;
        axi_wr(rdtl_pkg::ADDR_ASSIGN, {21'h0, 3'h3, rdtl_pkg::FUNC_REVERSE});
        axi_wr(rdtl_pkg::ADDR_POLAR, 32'h0000_0008);
        chk_dir("nc rev open", 3'b010);
        sw_prog <= 8'h08;
        chk_dir("nc rev closed", 3'b001);
        $display("Test polarity done");
        // Reset with forward held: ignored until source set, then runs at once
        sw_prog <= 8'h00;
        sw_fwd <= 1;
        keypad_run <= 0;
        aresetn <= 0;
        repeat (2) @(posedge aclk);
        aresetn <= 1;
        chk_dir("reset src off", 3'b001);
        axi_wr(rdtl_pkg::ADDR_CTRL, 32'h0000_0001);
        chk_dir("run at start", 3'b100);
        $display("Test mid-run reset done");
        axi_wr(8'h10, 32'h0000_0001);
        chk("unmapped wr resp", {30'h0, rdtl_pkg::AXI_DECERR}, {30'h0, rsp});
        axi_rd(8'h10);
        chk("unmapped resp", {30'h0, rdtl_pkg::AXI_DECERR}, {30'h0, rsp});
        chk("unmapped data", 32'h0000_0000, rd);
        $display("Test unmapped done");
        test_done();
    end
endmodule
